// file: mcs_pkg.sv
// Constants shared by the main clock select, prescale and start-up block.
package mcs_pkg;
    // Main source select codes.
    localparam logic [1:0] SRC_FAST      = 2'h0;
    localparam logic [1:0] SRC_SLOW      = 2'h1;
    localparam logic [1:0] SRC_EXT       = 2'h2;
    localparam logic [1:0] SRC_RESET     = SRC_FAST;
    // Prescale codes: 0..8 give division by 2**code.
    localparam logic [3:0] PS_MAX        = 4'h8;
    localparam logic [3:0] PS_RESET      = 4'h3;
    localparam int         DIV_W         = 8;
    // Change protection: window of instruction cycles after the signature.
    localparam logic [2:0] PROT_WINDOW   = 3'h4;
    // Arbitrary neutral signature value.
    localparam logic [7:0] PROT_SIG      = 8'hA5;
    // Start-up times in their own units.
    localparam int         SLOW_OSC_KHZ  = 128;
    localparam int         RST_DELAY_MS  = 64;
    localparam int         RST_LONG_MS   = 128;
    localparam logic [4:0] OSC_SETTLE    = 5'h06;
    localparam logic [4:0] CONF_CYCLES   = 5'h15;
    localparam int         WAKE_SLOW_US  = 60;
    localparam int         CLK_MHZ       = 10;
    // Derived counts (slow oscillator edges and sampling clock cycles).
    localparam int         RST_DELAY_CYC = RST_DELAY_MS * SLOW_OSC_KHZ;
    localparam int         RST_LONG_CYC  = RST_LONG_MS * SLOW_OSC_KHZ;
    localparam int         WAKE_SLOW_CYC = WAKE_SLOW_US * CLK_MHZ;
    localparam int         CNT_W         = 15;
    // Trim value held before the non-volatile load.
    localparam logic [7:0] TRIM_RESET    = 8'h00;
    // Start-up and sleep sequence states.
    typedef enum logic [2:0] {
        ST_DELAY,
        ST_OSC,
        ST_CONF,
        ST_RUN,
        ST_PDOWN,
        ST_WAKE,
        ST_WAKE_SLOW
    } mcs_state_t;
endpackage : mcs_pkg

// file: mcs_top.sv
// Main clock source select, system clock prescaler and start-up sequencer.
// Function
// - Select code 0 picks the calibrated internal fast oscillator as main clock.
// - Select code 2 picks the external clock input as main clock.
// - Select code 1 picks the internal 128 kHz oscillator as main clock.
// - Run-time source change produces no glitch or runt pulse on main clock.
// - After any reset: fast oscillator selected, system clock is main divided by 8.
// - Prescaler works on every source and clocks CPU and peripherals.
// - Prescale change gives no glitch and no period faster than old or new.
// - Prescaler is a counter on main clock, its state hidden from software.
// - New prescale effective at the next fall of the old divided clock, within one old period.
// - Internal reset asserts at once on rst_n_i, two cycles after a reset source, and holds until start-up has finished.
// - First step counts full 64 ms delay on the slow oscillator.
// - Second step waits 6 fast oscillator cycles for stability.
// - Last step spends 21 system cycles loading configuration and oscillator trim.
// - With undervoltage detection on, power-up delay becomes 128 ms.
// - Power-down wake skips delay, counts 6 cycles of selected main clock.
// - Wake from idle, noise reduction or standby adds no settling delay.
// - With detector disabled in sleep, wake takes about 60 microseconds.
// - Watchdog and reset time-out keep using the slow oscillator.
// - Converter clock keeps running while the CPU clock halts.
// - Prescale resets to 3; codes 0..8 divide by powers of two.
// - Select and prescale writes need the signature within four instruction cycles.
`timescale 1ns/100ps

module mcs_top
    import mcs_pkg::*;
#(
    parameter int RST_DELAY = RST_DELAY_CYC,
    parameter int RST_LONG  = RST_LONG_CYC
) (
    // Clock and reset.
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    // Oscillator and pin inputs from outside the clock domain.
    input  wire logic       fast_osc_i,
    input  wire logic       slow_osc_i,
    input  wire logic       external_clock_input_i,
    input  wire logic       reset_src_n_i,
    // Configuration and sleep control.
    input  wire logic       undervoltage_detector_en_i,
    input  wire logic       undervoltage_sw_off_i,
    input  wire logic       pdown_enter_i,
    input  wire logic       wake_pdown_i,
    input  wire logic       wake_light_i,
    input  wire logic [7:0] nvm_trim_i,
    // Software control fields.
    input  wire logic       change_protect_reg_we_i,
    input  wire logic       main_clock_settings_reg_we_i,
    input  wire logic       prescale_reg_we_i,
    input  wire logic       oscillator_trim_reg_we_i,
    input  wire logic [7:0] wdata_i,
    // Clocks and status out.
    output logic            main_clk_o,
    output logic            sys_clk_o,
    output logic            cpu_clk_o,
    output logic            converter_clock_o,
    output logic            wdt_clk_o,
    output logic            internal_rst_n_o,
    output logic            cpu_run_o,
    output logic [1:0]      main_source_select_o,
    output logic [3:0]      prescale_select_o,
    output logic [7:0]      oscillator_trim_reg_o
);

    // Counts beyond the counter width cannot be served.
    initial begin
        if (RST_DELAY < 1 || RST_LONG < RST_DELAY || RST_LONG >= (1 << CNT_W)) begin
            $error("mcs_top: reset delay parameters out of range");
        end
    end

    localparam logic [CNT_W-1:0] DLY_SHORT = CNT_W'(RST_DELAY - 1);
    localparam logic [CNT_W-1:0] DLY_LONG  = CNT_W'(RST_LONG - 1);
    localparam logic [CNT_W-1:0] WAKE_SLOW = CNT_W'(WAKE_SLOW_CYC - 1);

    // Two-stage synchronisers, plus a third stage for edge detection.
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [2:0] sync3_q;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            sync3_q <= 3'h0;
        end else begin
            sync1_q <= {reset_src_n_i, external_clock_input_i, slow_osc_i, fast_osc_i};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q[2:0];
        end
    end

    logic fast_lvl;
    logic slow_lvl;
    logic ext_lvl;
    logic src_ok;
    logic fast_rise;
    logic slow_rise;
    assign fast_lvl  = sync2_q[0];
    assign slow_lvl  = sync2_q[1];
    assign ext_lvl   = sync2_q[2];
    assign src_ok    = sync2_q[3];
    assign fast_rise = sync2_q[0] & ~sync3_q[0];
    assign slow_rise = sync2_q[1] & ~sync3_q[1];

    // Level of a source by its select code.
    function automatic logic src_level(input logic [1:0] sel, input logic f,
                                       input logic s, input logic e);
        logic lvl;
        lvl = 1'b0;
        case (sel)
            SRC_FAST: lvl = f;
            SRC_SLOW: lvl = s;
            SRC_EXT:  lvl = e;
            default:  lvl = 1'b0;
        endcase
        return lvl;
    endfunction : src_level

    // Divided clock tap for a prescale code.
    function automatic logic div_tap(input logic [3:0] ps, input logic m,
                                     input logic [DIV_W-1:0] cnt);
        logic lvl;
        lvl = m;
        if (ps != 4'h0) begin
            lvl = cnt[3'(ps - 4'h1)];
        end
        return lvl;
    endfunction : div_tap

    // Clock generation and control state.
    logic [1:0]       sel_cur_q, sel_cur_d;
    logic [1:0]       sel_new_q, sel_new_d;
    logic             hold_q, hold_d;
    logic             main_q, main_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic [3:0]       ps_cur_q, ps_cur_d;
    logic [3:0]       ps_new_q, ps_new_d;
    logic             sys_q, sys_d;
    logic             cpu_q, cpu_d;
    logic             wdt_q, wdt_d;
    logic [2:0]       prot_q, prot_d;
    logic [7:0]       trim_q, trim_d;
    logic             main_rise;
    logic             sys_rise;
    logic             unlocked;
    logic             run;

    // Source switch, prescaler, change protection and trim next values.
    always_comb begin
        sel_cur_d = sel_cur_q;
        sel_new_d = sel_new_q;
        hold_d    = hold_q;
        div_d     = div_q;
        ps_cur_d  = ps_cur_q;
        ps_new_d  = ps_new_q;
        prot_d    = prot_q;
        trim_d    = trim_q;
        unlocked  = (prot_q != 3'h0);
        // The main clock is parked low while the source changes: it is gated off only
        // once it is low, and reopened only while the new source is low, so no runt.
        if (!hold_q && sel_new_q != sel_cur_q && !main_q) begin
            hold_d = 1'b1;
        end
        if (hold_q && !src_level(sel_new_q, fast_lvl, slow_lvl, ext_lvl)) begin
            sel_cur_d = sel_new_q;
            hold_d    = 1'b0;
        end
        main_d    = ~hold_d & src_level(sel_cur_d, fast_lvl, slow_lvl, ext_lvl);
        main_rise = main_d & ~main_q;
        // The counter steps on main clock edges only; it has no software view.
        if (main_rise) begin
            div_d = div_q + DIV_W'(1);
            // The new setting is taken where the old divided clock falls, and the
            // counter restarts, so that edge is stretched rather than shortened.
            if (ps_new_q != ps_cur_q && (div_d & DIV_W'((9'h001 << ps_cur_q) - 9'h001))
                == DIV_W'(0)) begin
                ps_cur_d = ps_new_q;
                div_d    = DIV_W'(0);
            end
        end
        sys_d    = div_tap(ps_cur_d, main_d, div_d);
        sys_rise = sys_d & ~sys_q;
        // Protection window counts system clock rising edges.
        if (sys_rise && prot_q != 3'h0) begin
            prot_d = prot_q - 3'h1;
        end
        if (change_protect_reg_we_i && wdata_i == PROT_SIG) begin
            prot_d = PROT_WINDOW;
        end
        if (main_clock_settings_reg_we_i && unlocked && wdata_i[1:0] != 2'h3) begin
            sel_new_d = wdata_i[1:0];
        end
        if (prescale_reg_we_i && unlocked && wdata_i[3:0] <= PS_MAX) begin
            ps_new_d = wdata_i[3:0];
        end
        if (oscillator_trim_reg_we_i) begin
            trim_d = wdata_i;
        end
        // A reset source counts as a reset, so the defaults return; the source switch
        // and the prescale change then go through their glitch-free paths as usual.
        if (!src_ok) begin
            sel_new_d = SRC_RESET;
            ps_new_d  = PS_RESET;
            prot_d    = 3'h0;
        end
        cpu_d = sys_d & run;
        wdt_d = slow_lvl;
    end

    // Start-up sequencer state.
    mcs_state_t     st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic           por_q, por_d;
    logic           rst_hold;

    assign run = (st_q == ST_RUN);

    // Start-up and wake sequence next values.
    always_comb begin
        st_d     = st_q;
        cnt_d    = cnt_q;
        por_d    = por_q;
        rst_hold = (st_q == ST_DELAY) || (st_q == ST_OSC) || (st_q == ST_CONF);
        case (st_q)
            ST_DELAY: begin
                // Full delay always counted; supply level is not watched.
                if (slow_rise) begin
                    if (cnt_q == ((por_q && undervoltage_detector_en_i) ? DLY_LONG
                                                                        : DLY_SHORT)) begin
                        st_d  = ST_OSC;
                        cnt_d = CNT_W'(0);
                    end else begin
                        cnt_d = cnt_q + CNT_W'(1);
                    end
                end
            end
            ST_OSC: begin
                if (fast_rise) begin
                    if (cnt_q == CNT_W'(OSC_SETTLE - 5'h01)) begin
                        st_d  = ST_CONF;
                        cnt_d = CNT_W'(0);
                    end else begin
                        cnt_d = cnt_q + CNT_W'(1);
                    end
                end
            end
            ST_CONF: begin
                if (sys_rise) begin
                    if (cnt_q == CNT_W'(CONF_CYCLES - 5'h01)) begin
                        st_d  = ST_RUN;
                        por_d = 1'b0;
                    end else begin
                        cnt_d = cnt_q + CNT_W'(1);
                    end
                end
            end
            ST_RUN: begin
                if (pdown_enter_i) begin
                    st_d = ST_PDOWN;
                end
            end
            ST_PDOWN: begin
                cnt_d = CNT_W'(0);
                if (wake_pdown_i) begin
                    st_d = undervoltage_sw_off_i ? ST_WAKE_SLOW : ST_WAKE;
                end else if (wake_light_i) begin
                    st_d = ST_RUN;
                end
            end
            ST_WAKE: begin
                if (main_rise) begin
                    if (cnt_q == CNT_W'(OSC_SETTLE - 5'h01)) begin
                        st_d = ST_RUN;
                    end else begin
                        cnt_d = cnt_q + CNT_W'(1);
                    end
                end
            end
            ST_WAKE_SLOW: begin
                if (cnt_q == WAKE_SLOW) begin
                    st_d = ST_RUN;
                end else begin
                    cnt_d = cnt_q + CNT_W'(1);
                end
            end
            default: begin
                st_d  = ST_DELAY;
                cnt_d = CNT_W'(0);
            end
        endcase
        // A held reset source restarts the sequence; an unsteady external clock
        // must be covered by the outside party holding this source low.
        if (!src_ok) begin
            st_d  = ST_DELAY;
            cnt_d = CNT_W'(0);
        end
    end

    // Trim is loaded when the configuration step begins.
    logic [7:0] trim_nx;
    assign trim_nx = (st_q == ST_OSC && st_d == ST_CONF) ? nvm_trim_i : trim_d;

    // All clocked state except the synchronisers.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_cur_q <= SRC_RESET;
            sel_new_q <= SRC_RESET;
            hold_q    <= 1'b0;
            main_q    <= 1'b0;
            div_q     <= DIV_W'(0);
            ps_cur_q  <= PS_RESET;
            ps_new_q  <= PS_RESET;
            sys_q     <= 1'b0;
            cpu_q     <= 1'b0;
            wdt_q     <= 1'b0;
            prot_q    <= 3'h0;
            trim_q    <= TRIM_RESET;
            st_q      <= ST_DELAY;
            cnt_q     <= CNT_W'(0);
            por_q     <= 1'b1;
        end else begin
            sel_cur_q <= sel_cur_d;
            sel_new_q <= sel_new_d;
            hold_q    <= hold_d;
            main_q    <= main_d;
            div_q     <= div_d;
            ps_cur_q  <= ps_cur_d;
            ps_new_q  <= ps_new_d;
            sys_q     <= sys_d;
            cpu_q     <= cpu_d;
            wdt_q     <= wdt_d;
            prot_q    <= prot_d;
            trim_q    <= trim_nx;
            st_q      <= st_d;
            cnt_q     <= cnt_d;
            por_q     <= por_d;
        end
    end

    // Reset drops combinationally with rst_n_i; a reset source reaches it through the two-stage synchroniser.
    assign internal_rst_n_o      = rst_n_i & src_ok & ~rst_hold;
    assign main_clk_o            = main_q;
    assign sys_clk_o             = sys_q;
    assign cpu_clk_o             = cpu_q;
    assign converter_clock_o     = main_q;
    assign wdt_clk_o             = wdt_q;
    assign cpu_run_o             = run;
    assign main_source_select_o  = sel_new_q;
    assign prescale_select_o     = ps_new_q;
    assign oscillator_trim_reg_o = trim_q;

    // Assertions guarding the behaviour above.
    default clocking mcs_cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    main_park_low_a: assert property (hold_q |-> !main_q)
        else $error("main clock not parked low during switch");
    main_follow_a: assert property (!hold_d |=> main_q == $past(src_level(sel_cur_d,
        fast_lvl, slow_lvl, ext_lvl)))
        else $error("main clock does not follow selected source");
    reserved_sel_a: assert property (sel_new_q != 2'h3)
        else $error("reserved source code stored");
    reserved_ps_a: assert property (ps_new_q <= PS_MAX)
        else $error("reserved prescale code stored");
    locked_write_a: assert property ((prot_q == 3'h0 && !change_protect_reg_we_i)
        |=> $stable(sel_new_q) && $stable(ps_new_q))
        else $error("protected field changed while locked");
    rst_hold_a: assert property ((st_q == ST_CONF) |-> !internal_rst_n_o)
        else $error("internal reset released before configuration end");
    src_reset_a: assert property (!src_ok |=> st_q == ST_DELAY)
        else $error("reset source did not restart sequence");
    light_wake_a: assert property ((st_q == ST_PDOWN && !wake_pdown_i && wake_light_i
        && src_ok) |=> run)
        else $error("light wake was delayed");
    slow_wake_a: assert property ((st_q == ST_PDOWN && wake_pdown_i
        && undervoltage_sw_off_i && src_ok) |=> (st_q == ST_WAKE_SLOW) [*8])
        else $error("slow wake ended too soon");
    cpu_gate_a: assert property (!run |=> !cpu_q)
        else $error("cpu clock runs while halted");

endmodule : mcs_top

// file: mcs_clk_src.sv
// Model of the oscillators and the external clock pin around the clock control block.
`timescale 1ns/100ps

module mcs_clk_src #(
    parameter int FAST_HALF = 200,
    parameter int SLOW_HALF = 800,
    parameter int EXT_HALF  = 300
) (
    // Free running clock levels.
    output logic fast_osc_o,
    output logic slow_osc_o,
    output logic ext_clk_o
);
    // Odd start offsets keep every source edge away from the sampling clock edges.
    initial begin
        fast_osc_o = 1'b0;
        #17;
        forever #(FAST_HALF) fast_osc_o = ~fast_osc_o;
    end

    // The slow oscillator also feeds the watchdog and the reset delay count.
    initial begin
        slow_osc_o = 1'b0;
        #29;
        forever #(SLOW_HALF) slow_osc_o = ~slow_osc_o;
    end

    // A fixed rate, so the pin never moves by more than 2% between cycles.
    initial begin
        ext_clk_o = 1'b0;
        #41;
        forever #(EXT_HALF) ext_clk_o = ~ext_clk_o;
    end
endmodule : mcs_clk_src

// file: mcs_top_bench.sv
// Self-checking testbench for the main clock select, prescale and start-up block.
`timescale 1ns/100ps

module mcs_top_bench
    import mcs_pkg::*;
;
    localparam logic [7:0] TRIM_NVM = 8'h5C;

    logic       mclk_i;
    logic       rst_n_i;
    logic       fast_osc_i;
    logic       slow_osc_i;
    logic       external_clock_input_i;
    logic       reset_src_n_i;
    logic       undervoltage_detector_en_i;
    logic       undervoltage_sw_off_i;
    logic       pdown_enter_i;
    logic       wake_pdown_i;
    logic       wake_light_i;
    logic [7:0] nvm_trim_i;
    logic       change_protect_reg_we_i;
    logic       main_clock_settings_reg_we_i;
    logic       prescale_reg_we_i;
    logic       oscillator_trim_reg_we_i;
    logic [7:0] wdata_i;
    logic       main_clk_o;
    logic       sys_clk_o;
    logic       cpu_clk_o;
    logic       converter_clock_o;
    logic       wdt_clk_o;
    logic       internal_rst_n_o;
    logic       cpu_run_o;
    logic [1:0] main_source_select_o;
    logic [3:0] prescale_select_o;
    logic [7:0] oscillator_trim_reg_o;
    int         miscompares = 0;
    int         num_checks  = 0;

    // Short reset delays keep the start-up runs brief.
    mcs_top #(.RST_DELAY(8), .RST_LONG(16)) uut (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .fast_osc_i(fast_osc_i), .slow_osc_i(slow_osc_i),
        .external_clock_input_i(external_clock_input_i), .reset_src_n_i(reset_src_n_i),
        .undervoltage_detector_en_i(undervoltage_detector_en_i),
        .undervoltage_sw_off_i(undervoltage_sw_off_i), .pdown_enter_i(pdown_enter_i),
        .wake_pdown_i(wake_pdown_i), .wake_light_i(wake_light_i), .nvm_trim_i(nvm_trim_i),
        .change_protect_reg_we_i(change_protect_reg_we_i),
        .main_clock_settings_reg_we_i(main_clock_settings_reg_we_i),
        .prescale_reg_we_i(prescale_reg_we_i),
        .oscillator_trim_reg_we_i(oscillator_trim_reg_we_i), .wdata_i(wdata_i),
        .main_clk_o(main_clk_o), .sys_clk_o(sys_clk_o), .cpu_clk_o(cpu_clk_o),
        .converter_clock_o(converter_clock_o), .wdt_clk_o(wdt_clk_o),
        .internal_rst_n_o(internal_rst_n_o), .cpu_run_o(cpu_run_o),
        .main_source_select_o(main_source_select_o), .prescale_select_o(prescale_select_o),
        .oscillator_trim_reg_o(oscillator_trim_reg_o)
    );

    // Fast source has a 4 cycle period, slow 16 cycles, external pin 6 cycles.
    mcs_clk_src src (
        .fast_osc_o(fast_osc_i), .slow_osc_o(slow_osc_i), .ext_clk_o(external_clock_input_i)
    );

    // The 10 MHz sampling clock.
    initial mclk_i = 1'b0;
    always #50 mclk_i = ~mclk_i;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cycles(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : cycles

    // Optional signature, a gap of edges, then one field write; ps picks prescale or source.
    task automatic prot_write(input logic sig, input logic ps, input logic [7:0] d, input int gap);
        @(posedge mclk_i);
        change_protect_reg_we_i <= sig;
        wdata_i <= PROT_SIG;
        @(posedge mclk_i);
        change_protect_reg_we_i <= 1'b0;
        repeat (gap) @(posedge mclk_i);
        prescale_reg_we_i <= ps;
        main_clock_settings_reg_we_i <= ~ps;
        wdata_i <= d;
        @(posedge mclk_i);
        prescale_reg_we_i <= 1'b0;
        main_clock_settings_reg_we_i <= 1'b0;
        cycles(2);
    endtask : prot_write

    // Cycles between two rises of main (0), system (1) or watchdog (2) clock; 0 on a stall.
    task automatic period(input int sel, output int n);
        int   k;
        int   r;
        logic p;
        logic c;
        n = 0;
        r = 0;
        p = 1'b1;
        for (k = 0; k < 400 && r < 2; k++) begin
            @(posedge mclk_i);
            #1;
            c = (sel == 0) ? main_clk_o : (sel == 1) ? sys_clk_o : wdt_clk_o;
            if (r == 1) n++;
            if (c === 1'b1 && p === 1'b0) r++;
            p = c;
        end
    endtask : period

    // Reset state, then the length of the start-up sequence and the trim load.
    task automatic t_startup(input int lo);
        int n;
        n = 0;
        chk(main_source_select_o, SRC_FAST);
        chk(prescale_select_o, PS_RESET);
        chk(internal_rst_n_o, 1'b0);
        while (internal_rst_n_o !== 1'b1 && n < 3000) begin
            @(posedge mclk_i);
            n++;
        end
        chk(n >= lo && n < 1500, 1'b1);
        chk(oscillator_trim_reg_o, TRIM_NVM);
        period(1, n);
        chk(8'(n), 8'h20);
    endtask : t_startup

    // Refused writes, then each short division measured on the system clock.
    task automatic t_prescale;
        int n;
        int i;
        prot_write(1'b0, 1'b1, 8'h00, 0);
        chk(prescale_select_o, PS_RESET);
        prot_write(1'b1, 1'b1, 8'h09, 0);
        chk(prescale_select_o, PS_RESET);
        prot_write(1'b1, 1'b1, {4'h0, PS_MAX}, 0);
        chk(prescale_select_o, PS_MAX);
        for (i = 2; i >= 0; i--) begin
            prot_write(1'b1, 1'b1, 8'(i), 0);
            cycles(1100);
            chk(prescale_select_o, 4'(i));
            period(1, n);
            chk(8'(n), 8'(4 << i));
        end
        // A late field write after four system rises must be refused.
        prot_write(1'b1, 1'b1, 8'h01, 30);
        chk(prescale_select_o, 4'h0);
    endtask : t_prescale

    // Each valid source code measured on main and system clocks, converter compared with main; watchdog measured once.
    task automatic t_source;
        int         n;
        int         i;
        int         per[3]   = '{16, 6, 4};
        logic [1:0] codes[3] = '{SRC_SLOW, SRC_EXT, SRC_FAST};
        prot_write(1'b1, 1'b0, 8'h03, 0);
        chk(main_source_select_o, SRC_FAST);
        for (i = 0; i < 3; i++) begin
            prot_write(1'b1, 1'b0, 8'(codes[i]), 0);
            cycles(80);
            chk(main_source_select_o, codes[i]);
            period(0, n);
            chk(8'(n), 8'(per[i]));
            period(1, n);
            chk(8'(n), 8'(per[i]));
            chk(converter_clock_o, main_clk_o);
        end
        period(2, n);
        chk(8'(n), 8'h10);
    endtask : t_source

    // Enter power-down, wake by kind 0 light, 1 settling, 2 detector off; time the wake.
    task automatic t_wake(input int kind, input int lo, input int hi);
        int n;
        n = 0;
        @(posedge mclk_i);
        pdown_enter_i <= 1'b1;
        @(posedge mclk_i);
        pdown_enter_i <= 1'b0;
        cycles(20);
        chk(cpu_run_o, 1'b0);
        chk(cpu_clk_o, 1'b0);
        chk(converter_clock_o, main_clk_o);
        undervoltage_sw_off_i <= (kind == 2);
        wake_light_i <= (kind == 0);
        wake_pdown_i <= (kind != 0);
        @(posedge mclk_i);
        wake_light_i <= 1'b0;
        wake_pdown_i <= 1'b0;
        while (cpu_run_o !== 1'b1 && n < 1000) begin
            @(posedge mclk_i);
            n++;
        end
        chk(n >= lo && n <= hi, 1'b1);
        undervoltage_sw_off_i <= 1'b0;
    endtask : t_wake

    // A reset source in mid-run restores source, division and trim.
    task automatic t_resetsrc;
        prot_write(1'b1, 1'b0, 8'(SRC_SLOW), 0);
        prot_write(1'b1, 1'b1, 8'h01, 0);
        @(posedge mclk_i);
        oscillator_trim_reg_we_i <= 1'b1;
        wdata_i <= 8'h3C;
        @(posedge mclk_i);
        oscillator_trim_reg_we_i <= 1'b0;
        cycles(2);
        chk(oscillator_trim_reg_o, 8'h3C);
        reset_src_n_i <= 1'b0;
        cycles(4);
        chk(internal_rst_n_o, 1'b0);
        chk(cpu_run_o, 1'b0);
        reset_src_n_i <= 1'b1;
        cycles(4);
        t_startup(736);
    endtask : t_resetsrc

    task automatic results;
        if (miscompares == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    // A hang past more than four times the expected run length ends the run as a failure.
    initial begin
        #3000000;
        miscompares++;
        results;
    end

    // Main sequence: power-up with the detector on, then the scenarios in turn.
    initial begin
        rst_n_i = 1'b0;
        reset_src_n_i = 1'b1;
        undervoltage_detector_en_i = 1'b1;
        undervoltage_sw_off_i = 1'b0;
        pdown_enter_i = 1'b0;
        wake_pdown_i = 1'b0;
        wake_light_i = 1'b0;
        nvm_trim_i = TRIM_NVM;
        change_protect_reg_we_i = 1'b0;
        main_clock_settings_reg_we_i = 1'b0;
        prescale_reg_we_i = 1'b0;
        oscillator_trim_reg_we_i = 1'b0;
        wdata_i = 8'h00;
        cycles(2);
        rst_n_i <= 1'b1;
        t_startup(800);
        undervoltage_detector_en_i <= 1'b0;
        t_prescale;
        t_source;
        t_wake(0, 0, 3);
        t_wake(1, 18, 40);
        t_wake(2, 580, 640);
        t_resetsrc;
        results;
    end
endmodule : mcs_top_bench
